// >>> core/hostport_defines.svh
/*
  timing counts, address map and reset values of the isa host port.
  assumes inclusion by bare name from the host port files.
*/
`ifndef HOSTPORT_DEFINES_SVH
`define HOSTPORT_DEFINES_SVH

`define HP_CLK_PERIOD_NS 100
`define HP_BYTE_ACCESS_NS 200
`define HP_BYTE_CYCLES ((`HP_BYTE_ACCESS_NS + `HP_CLK_PERIOD_NS - 1) / `HP_CLK_PERIOD_NS)
`define HP_SYNC_STAGES 2
`define HP_IO_BASE 10'h300
`define HP_IO_STEP_SHIFT 5
`define HP_IO_WINDOW_BYTES 5'h18
`define HP_ROM_BASE 20'hc8000
`define HP_ROM_SIZE_SHIFT 14
`define HP_PA_LOW_BITS 10
`define HP_PF_STRIDE 16'h0002
`define HP_RESET_IO_CODE 2'h3
`define HP_RESET_SHARED 1'b0

`endif

// >>> core/hostport_pkg.sv
/*
  types of the isa host port: sequencer states and the sampled pin bundle.
  assumes nothing beyond a systemverilog compiler.
*/
package hostport_pkg;

    typedef enum logic [1:0] {
        ST_WAIT_STRAP,
        ST_IDLE,
        ST_ACCESS,
        ST_HOLD
    } state_t;

    typedef struct packed {
        logic [19:0] sa;
        logic aen;
        logic ior_n;
        logic iow_n;
        logic memr_n;
        logic memw_n;
        logic sbhe_n;
        logic rom_match_n;
        logic shared_match_n;
        logic dack_n;
        logic shared_strap_n;
        logic [1:0] io_base_strap;
        logic [15:0] sd;
        logic [15:0] pa;
        logic [7:0] pd;
    } host_pins_t;

endpackage

// >>> core/sync_2ff.sv
/*
  two flip-flop synchroniser for a bundle of pin inputs.
  assumes each bit is sampled on its own; multi-bit words must be stable when read.
*/
`timescale 1ns/1ns
module sync_2ff #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] data_i,
    output logic [WIDTH-1:0] data_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] data_q;

    generate
        if (WIDTH < 1)
        begin : g_check
            $error("sync_2ff width must be at least one");
        end
    endgenerate

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= '0;
            data_q <= '0;
        end
        else
        begin
            meta_q <= data_i;
            data_q <= meta_q;
        end
    end

    assign data_o = data_q;
endmodule

// >>> core/byte_pair.sv
/*
  collects two private bus bytes into one host word.
  assumes lane 0 is the even byte and lane 1 the odd byte.
*/
`timescale 1ns/1ns
module byte_pair (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic lane_i,
    input wire logic [7:0] byte_i,
    output logic [15:0] word_o
);
    logic [15:0] word_q;
    logic [15:0] word_d;

    always_comb
    begin
        word_d = word_q;
        if (load_i)
        begin
            if (lane_i)
            begin
                word_d[15:8] = byte_i;
            end
            else
            begin
                word_d[7:0] = byte_i;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            word_q <= 16'h0000;
        end
        else
        begin
            word_q <= word_d;
        end
    end

    assign word_o = word_q;
endmodule

// >>> core/isa_shared_memory_host_port.sv
/*
  isa host port: strap capture, i/o and boot rom decode, 8 to 16 bit
  conversion on the private bus and sram read prefetch.
  assumes all host pins are asynchronous and pass the synchroniser, and that
  the host holds its strobe while the wait line is pulled.
*/
`timescale 1ns/1ns
`include "hostport_defines.svh"
module isa_shared_memory_host_port
    import hostport_pkg::*;
#(
    parameter int unsigned BYTE_CYCLES = `HP_BYTE_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [19:0] sa_i,
    input wire logic aen_i,
    input wire logic ior_n_i,
    input wire logic iow_n_i,
    input wire logic memr_n_i,
    input wire logic memw_n_i,
    input wire logic sbhe_n_i,
    input wire logic [15:0] sd_i,
    output logic [15:0] sd_o,
    output logic sd_oe_o,
    output logic iochrdy_o,
    output logic iochrdy_oe_o,
    output logic io_cs16_o,
    output logic io_cs16_oe_o,
    input wire logic rom_window_match_n_i,
    input wire logic shared_window_match_n_i,
    input wire logic shared_mode_strap_n_i,
    input wire logic [1:0] io_base_strap_i,
    input wire logic dack_n_i,
    output logic rom_chip_select_n_o,
    output logic sram_output_enable_n_o,
    output logic sram_write_enable_n_o,
    output logic addr_buffer_output_enable_n_o,
    input wire logic [15:0] private_addr_bus_i,
    output logic [9:0] private_addr_bus_o,
    output logic private_addr_bus_oe_o,
    input wire logic [7:0] private_data_bus_i,
    output logic [7:0] private_data_bus_o,
    output logic private_data_bus_oe_o,
    input wire logic dma_req_i,
    output logic dma_request_o,
    output logic dma_strobe_o,
    output logic io_select_o,
    output logic io_write_o,
    output logic [4:0] io_offset_o,
    output logic shared_mode_o
);
    localparam logic [3:0] LAST_WR = 4'(BYTE_CYCLES - 1);
    localparam logic [3:0] LAST_RD = 4'(BYTE_CYCLES + `HP_SYNC_STAGES - 1);
    localparam logic [3:0] SYNC_WAIT = 4'(`HP_SYNC_STAGES);
    localparam logic [19:0] ROM_BASE = `HP_ROM_BASE;

    generate
        if (BYTE_CYCLES < 2 || BYTE_CYCLES + `HP_SYNC_STAGES > 15)
        begin : g_check
            $error("byte access cycles out of range for the sequencer");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    host_pins_t pins_raw;
    host_pins_t p_s;
    logic [15:0] host_word;
    logic [15:0] pf_word;

    assign pins_raw = '{sa: sa_i, aen: aen_i, ior_n: ior_n_i, iow_n: iow_n_i,
        memr_n: memr_n_i, memw_n: memw_n_i, sbhe_n: sbhe_n_i,
        rom_match_n: rom_window_match_n_i, shared_match_n: shared_window_match_n_i,
        dack_n: dack_n_i, shared_strap_n: shared_mode_strap_n_i,
        io_base_strap: io_base_strap_i, sd: sd_i, pa: private_addr_bus_i,
        pd: private_data_bus_i};

    sync_2ff #(
        .WIDTH($bits(host_pins_t))
    ) u_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .data_i(pins_raw),
        .data_o(p_s)
    );

    ////////////////////////////////////////////////////////////////////////
    state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [1:0] loads_q, loads_d;
    logic shared_q, shared_d;
    logic [1:0] io_code_q, io_code_d;
    logic kind_sram_q, kind_sram_d;
    logic write_q, write_d;
    logic prefetch_q, prefetch_d;
    logic byte_q, byte_d;
    logic hi_pend_q, hi_pend_d;
    logic word_q, word_d;
    logic [15:0] paddr_q, paddr_d;
    logic [15:0] wdata_q, wdata_d;
    logic pf_valid_q, pf_valid_d;
    logic pf_pend_q, pf_pend_d;
    logic [15:0] pf_tag_q, pf_tag_d;
    logic [15:0] pf_next_q, pf_next_d;
    logic [15:0] sd_q, sd_d;
    logic sd_oe_q, sd_oe_d;
    logic chrdy_oe_q, chrdy_oe_d;
    logic cs16_oe_q, cs16_oe_d;
    logic rom_cs_n_q, rom_cs_n_d;
    logic sram_oe_n_q, sram_oe_n_d;
    logic sram_we_n_q, sram_we_n_d;
    logic abo_n_q, abo_n_d;
    logic [9:0] pa_q, pa_d;
    logic pa_oe_q, pa_oe_d;
    logic [7:0] pd_q, pd_d;
    logic pd_oe_q, pd_oe_d;
    logic drq_q, drq_d;
    logic dma_stb_q, dma_stb_d;
    logic io_sel_q, io_sel_d;
    logic io_wr_q, io_wr_d;
    logic [4:0] io_off_q, io_off_d;
    logic load_host, load_pf;

    logic ready, memr, memw, need_lo, need_hi;
    logic [9:0] io_base, io_rel;
    logic [5:0] rom_block;
    logic io_hit, rom_hit, sram_hit, pf_hit, busy_req;
    logic [3:0] last_cnt;
    logic [15:0] asm_word;

    always_comb
    begin
        ready = state_q != ST_WAIT_STRAP;
        memr = ready && !p_s.memr_n;
        memw = ready && !p_s.memw_n;
        need_hi = !p_s.sbhe_n;
        need_lo = !p_s.sa[0] || !need_hi;
        io_base = `HP_IO_BASE + {3'h0, io_code_q, 5'h00};
        io_rel = p_s.sa[9:0] - io_base;
        // same comparators in both modes
        io_hit = ready && !p_s.aen && p_s.sa[19:10] == 10'h000 && p_s.sa[9:0] >= io_base
            && io_rel < {5'h00, `HP_IO_WINDOW_BYTES};
        rom_block = ROM_BASE[19:`HP_ROM_SIZE_SHIFT] + {4'h0, io_code_q};
        if (shared_q)
        begin
            rom_hit = ready && !p_s.rom_match_n;
        end
        else
        begin
            rom_hit = ready && !p_s.aen
                && p_s.sa[19:`HP_ROM_SIZE_SHIFT] == rom_block;
        end
        sram_hit = ready && shared_q && !p_s.shared_match_n;
        pf_hit = pf_valid_q && need_lo && need_hi
            && {p_s.pa[15:10], p_s.sa[9:1], 1'b0} == pf_tag_q;
        busy_req = (memr && (rom_hit || sram_hit)) || (memw && sram_hit);
        last_cnt = write_q ? LAST_WR : LAST_RD;
        if (byte_q)
        begin
            asm_word = {p_s.pd, host_word[7:0]};
        end
        else
        begin
            asm_word = {host_word[15:8], p_s.pd};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        loads_d = loads_q;
        shared_d = shared_q;
        io_code_d = io_code_q;
        kind_sram_d = kind_sram_q;
        write_d = write_q;
        prefetch_d = prefetch_q;
        byte_d = byte_q;
        hi_pend_d = hi_pend_q;
        word_d = word_q;
        paddr_d = paddr_q;
        wdata_d = wdata_q;
        pf_valid_d = pf_valid_q;
        pf_pend_d = pf_pend_q;
        pf_tag_d = pf_tag_q;
        pf_next_d = pf_next_q;
        sd_d = sd_q;
        load_host = 1'b0;
        load_pf = 1'b0;
        case (state_q)
            ST_WAIT_STRAP:
            begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == SYNC_WAIT)
                begin
                    shared_d = !p_s.shared_strap_n;
                    io_code_d = p_s.io_base_strap;
                    cnt_d = 4'h0;
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE:
            begin
                cnt_d = 4'h0;
                loads_d = 2'h0;
                byte_d = !need_lo;
                hi_pend_d = need_lo && need_hi;
                word_d = need_lo && need_hi;
                paddr_d = {p_s.pa[15:10], p_s.sa[9:1], !need_lo};
                prefetch_d = 1'b0;
                if (memr && sram_hit && pf_hit)
                begin
                    sd_d = pf_word;
                    kind_sram_d = 1'b1;
                    write_d = 1'b0;
                    state_d = ST_HOLD;
                end
                else if (memr && (rom_hit || sram_hit))
                begin
                    kind_sram_d = sram_hit && !rom_hit;
                    write_d = 1'b0;
                    state_d = ST_ACCESS;
                end
                else if (memw && sram_hit)
                begin
                    kind_sram_d = 1'b1;
                    write_d = 1'b1;
                    wdata_d = p_s.sd;
                    if ({p_s.pa[15:10], p_s.sa[9:1], 1'b0} == pf_tag_q)
                    begin
                        pf_valid_d = 1'b0;
                    end
                    state_d = ST_ACCESS;
                end
                else if (pf_pend_q)
                begin
                    kind_sram_d = 1'b1;
                    write_d = 1'b0;
                    prefetch_d = 1'b1;
                    byte_d = 1'b0;
                    hi_pend_d = 1'b1;
                    paddr_d = pf_next_q;
                    pf_pend_d = 1'b0;
                    pf_valid_d = 1'b0;
                    state_d = ST_ACCESS;
                end
            end
            ST_ACCESS:
            begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == last_cnt)
                begin
                    cnt_d = 4'h0;
                    loads_d = loads_q + 2'h1;
                    load_host = !write_q && !prefetch_q;
                    load_pf = !write_q && prefetch_q;
                    if (hi_pend_q)
                    begin
                        byte_d = 1'b1;
                        hi_pend_d = 1'b0;
                        paddr_d[0] = 1'b1;
                    end
                    else if (prefetch_q)
                    begin
                        pf_tag_d = {p_s.pa[15:10], paddr_q[9:1], 1'b0};
                        pf_valid_d = 1'b1;
                        state_d = ST_IDLE;
                    end
                    else
                    begin
                        if (!write_q)
                        begin
                            sd_d = asm_word;
                        end
                        if (kind_sram_q && !write_q && word_q)
                        begin
                            pf_pend_d = 1'b1;
                            pf_next_d = {paddr_q[15:1], 1'b0} + `HP_PF_STRIDE;
                        end
                        state_d = ST_HOLD;
                    end
                end
            end
            ST_HOLD:
            begin
                if (!memr && !memw)
                begin
                    state_d = ST_IDLE;
                end
            end
            default:
            begin
                state_d = ST_WAIT_STRAP;
            end
        endcase
        chrdy_oe_d = busy_req && state_d != ST_HOLD;
        sd_oe_d = state_d == ST_HOLD && !write_d && memr;
        cs16_oe_d = io_hit && (!p_s.ior_n || !p_s.iow_n) && !rom_hit;
        rom_cs_n_d = !(memr && rom_hit);
        sram_oe_n_d = !(state_d == ST_ACCESS && kind_sram_d && !write_d);
        sram_we_n_d = !(state_d == ST_ACCESS && write_d && cnt_d != 4'h0);
        abo_n_d = !(shared_d || state_d == ST_ACCESS);
        pa_d = paddr_d[`HP_PA_LOW_BITS-1:0];
        pa_oe_d = state_d == ST_ACCESS;
        pd_d = byte_d ? wdata_d[15:8] : wdata_d[7:0];
        pd_oe_d = state_d == ST_ACCESS && write_d;
        drq_d = dma_req_i && !shared_d;
        dma_stb_d = dma_req_i && !shared_d && !p_s.dack_n;
        io_sel_d = io_hit && (!p_s.ior_n || !p_s.iow_n);
        io_wr_d = io_hit && !p_s.iow_n;
        io_off_d = io_rel[4:0];
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= ST_WAIT_STRAP;
            cnt_q <= 4'h0;
            loads_q <= 2'h0;
            shared_q <= `HP_RESET_SHARED;
            io_code_q <= `HP_RESET_IO_CODE;
            kind_sram_q <= 1'b0;
            write_q <= 1'b0;
            prefetch_q <= 1'b0;
            byte_q <= 1'b0;
            hi_pend_q <= 1'b0;
            word_q <= 1'b0;
            paddr_q <= 16'h0000;
            wdata_q <= 16'h0000;
            pf_valid_q <= 1'b0;
            pf_pend_q <= 1'b0;
            pf_tag_q <= 16'h0000;
            pf_next_q <= 16'h0000;
            sd_q <= 16'h0000;
            sd_oe_q <= 1'b0;
            chrdy_oe_q <= 1'b0;
            cs16_oe_q <= 1'b0;
            rom_cs_n_q <= 1'b1;
            sram_oe_n_q <= 1'b1;
            sram_we_n_q <= 1'b1;
            abo_n_q <= 1'b1;
            pa_q <= 10'h000;
            pa_oe_q <= 1'b0;
            pd_q <= 8'h00;
            pd_oe_q <= 1'b0;
            drq_q <= 1'b0;
            dma_stb_q <= 1'b0;
            io_sel_q <= 1'b0;
            io_wr_q <= 1'b0;
            io_off_q <= 5'h00;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            loads_q <= loads_d;
            shared_q <= shared_d;
            io_code_q <= io_code_d;
            kind_sram_q <= kind_sram_d;
            write_q <= write_d;
            prefetch_q <= prefetch_d;
            byte_q <= byte_d;
            hi_pend_q <= hi_pend_d;
            word_q <= word_d;
            paddr_q <= paddr_d;
            wdata_q <= wdata_d;
            pf_valid_q <= pf_valid_d;
            pf_pend_q <= pf_pend_d;
            pf_tag_q <= pf_tag_d;
            pf_next_q <= pf_next_d;
            sd_q <= sd_d;
            sd_oe_q <= sd_oe_d;
            chrdy_oe_q <= chrdy_oe_d;
            cs16_oe_q <= cs16_oe_d;
            rom_cs_n_q <= rom_cs_n_d;
            sram_oe_n_q <= sram_oe_n_d;
            sram_we_n_q <= sram_we_n_d;
            abo_n_q <= abo_n_d;
            pa_q <= pa_d;
            pa_oe_q <= pa_oe_d;
            pd_q <= pd_d;
            pd_oe_q <= pd_oe_d;
            drq_q <= drq_d;
            dma_stb_q <= dma_stb_d;
            io_sel_q <= io_sel_d;
            io_wr_q <= io_wr_d;
            io_off_q <= io_off_d;
        end
    end

    byte_pair u_host_pair (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .load_i(load_host),
        .lane_i(byte_q),
        .byte_i(p_s.pd),
        .word_o(host_word)
    );

    byte_pair u_pf_pair (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .load_i(load_pf),
        .lane_i(byte_q),
        .byte_i(p_s.pd),
        .word_o(pf_word)
    );

    // open-drain lines only ever pull low
    assign iochrdy_o = 1'b0 & chrdy_oe_q;
    assign io_cs16_o = 1'b0 & cs16_oe_q;
    assign sd_o = sd_q;
    assign sd_oe_o = sd_oe_q;
    assign iochrdy_oe_o = chrdy_oe_q;
    assign io_cs16_oe_o = cs16_oe_q;
    assign rom_chip_select_n_o = rom_cs_n_q;
    assign sram_output_enable_n_o = sram_oe_n_q;
    assign sram_write_enable_n_o = sram_we_n_q;
    assign addr_buffer_output_enable_n_o = abo_n_q;
    assign private_addr_bus_o = pa_q;
    assign private_addr_bus_oe_o = pa_oe_q;
    assign private_data_bus_o = pd_q;
    assign private_data_bus_oe_o = pd_oe_q;
    assign dma_request_o = drq_q;
    assign dma_strobe_o = dma_stb_q;
    assign io_select_o = io_sel_q;
    assign io_write_o = io_wr_q;
    assign io_offset_o = io_off_q;
    assign shared_mode_o = shared_q;

    ////////////////////////////////////////////////////////////////////////
    a_rom_cs_follow: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        memr && rom_hit |=> !rom_chip_select_n_o)
        else $error("rom select missing after match and read");
    a_rom_no_cs16: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !rom_chip_select_n_o |-> !io_cs16_oe_o)
        else $error("iocs16 driven during rom cycle");
    a_io_window: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        io_select_o |-> io_offset_o < 5'h18)
        else $error("i/o select outside 24 byte window");
    a_io_base: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ready && !p_s.aen && !p_s.ior_n && p_s.sa == {10'h000, 10'h300 + {3'h0, io_code_q, 5'h00}}
        |=> io_select_o && io_offset_o == 5'h00)
        else $error("i/o base not decoded at strap base");
    a_rom_c8000: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ready && !shared_q && io_code_q == 2'h0 && !p_s.aen && memr
        && p_s.sa[19:14] == 6'h32 |=> !rom_chip_select_n_o)
        else $error("rom window not at c8000 for base 300");
    a_write_no_oe: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !sram_write_enable_n_o |-> sram_output_enable_n_o && private_data_bus_oe_o)
        else $error("sram output enable active during write");
    a_mode_stable: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_q != ST_WAIT_STRAP |=> $stable(shared_q) && $stable(io_code_q))
        else $error("operating mode changed after strap capture");
    a_dma_master: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        dma_strobe_o |-> !shared_mode_o && $past(!p_s.dack_n))
        else $error("host memory strobe without mastership");
    a_word_two_bytes: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_q == ST_ACCESS && state_d == ST_HOLD && word_q |-> loads_q == 2'h1)
        else $error("word access did not take two byte reads");
    a_pf_hit_fast: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_q == ST_IDLE && memr && sram_hit && pf_hit
        |=> state_q == ST_HOLD ##1 sd_oe_o && sd_o == $past(pf_word, 2))
        else $error("prefetch hit not answered at once");
    a_sram_done: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_q == ST_IDLE && state_d == ST_ACCESS && !prefetch_d
        |=> ##[1:32] state_q == ST_HOLD)
        else $error("sram access did not complete in time");
endmodule

// >>> bench/priv_mem_model.sv
/* private bus sram and boot rom as seen by the host port.
   assumes the board buffer feeds the upper address lines from the host. */
`timescale 1ns/1ns
module priv_mem_model (
    input wire logic [5:0] upper_i,
    input wire logic [9:0] low_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic rom_cs_n_i,
    input wire logic [7:0] wdata_i,
    output logic [15:0] addr_o,
    output logic [7:0] data_o = 8'h00
);
    logic [7:0] mem [int];
    logic [15:0] wa;
    logic [7:0] wd;
    assign addr_o = {upper_i, low_i};
    // latch as the strobe falls: address and data move on the edge where it rises
    always @(negedge we_n_i)
    begin
        wa = addr_o;
        wd = wdata_i;
    end
    always @(posedge we_n_i) mem[wa] = wd;
    // a released bus shows the inverse of its last value
    always @(addr_o or oe_n_i or rom_cs_n_i)
        if (!rom_cs_n_i)
            data_o = addr_o[7:0] ^ 8'ha5;
        else if (!oe_n_i && mem.exists(addr_o))
            data_o = mem[addr_o];
        else
            data_o = ~data_o;
endmodule

// >>> bench/isa_shared_memory_host_port_tb.sv
/* self-checking bench of the isa host port in shared memory mode, then in bus-master mode.
   assumes the private bus model answers on the sram and rom strobes. */
`timescale 1ns/1ns
module isa_shared_memory_host_port_tb;
    logic clock_i = 0, rst_n_i = 0, aen_i = 0, ior_n_i = 1, iow_n_i = 1;
    logic memr_n_i = 1, memw_n_i = 1, sbhe_n_i = 0, dack_n_i = 1, dma_req_i = 0;
    logic rom_window_match_n_i = 1, shared_window_match_n_i = 1, shared_mode_strap_n_i = 0;
    logic [1:0] io_base_strap_i = 0;
    logic [19:0] sa_i = 0;
    logic [15:0] sd_i = 0, sd_o, private_addr_bus_i;
    logic [9:0] private_addr_bus_o;
    logic [7:0] private_data_bus_i, private_data_bus_o;
    logic [4:0] io_offset_o;
    logic sd_oe_o, iochrdy_oe_o, rom_chip_select_n_o, sram_output_enable_n_o;
    logic sram_write_enable_n_o, io_select_o, shared_mode_o;
    logic io_write_o, io_cs16_oe_o, dma_request_o, dma_strobe_o, req_seen;
    logic addr_buffer_output_enable_n_o;
    int err_total = 0, checks = 0, seed = 32'h38abf97d;
    int offs[3] = '{0, 23, 24};
    logic [7:0] ref_mem [int];
    logic [15:0] a;
    always #50 clock_i = ~clock_i;
    isa_shared_memory_host_port u_dut (.clock_i, .rst_n_i, .sa_i, .aen_i, .ior_n_i, .iow_n_i,
        .memr_n_i, .memw_n_i, .sbhe_n_i, .sd_i, .sd_o, .sd_oe_o, .iochrdy_o(), .iochrdy_oe_o,
        .io_cs16_o(), .io_cs16_oe_o, .rom_window_match_n_i, .shared_window_match_n_i,
        .shared_mode_strap_n_i, .io_base_strap_i, .dack_n_i, .rom_chip_select_n_o,
        .sram_output_enable_n_o, .sram_write_enable_n_o, .addr_buffer_output_enable_n_o,
        .private_addr_bus_i, .private_addr_bus_o, .private_addr_bus_oe_o(),
        .private_data_bus_i, .private_data_bus_o, .private_data_bus_oe_o(), .dma_req_i,
        .dma_request_o, .dma_strobe_o, .io_select_o, .io_write_o, .io_offset_o,
        .shared_mode_o);
    priv_mem_model u_mem (.upper_i(sa_i[15:10]), .low_i(private_addr_bus_o),
        .oe_n_i(sram_output_enable_n_o), .we_n_i(sram_write_enable_n_o),
        .rom_cs_n_i(rom_chip_select_n_o), .wdata_i(private_data_bus_o),
        .addr_o(private_addr_bus_i), .data_o(private_data_bus_i));
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #5;
        dma_req_i = 1'($random(seed));
    endtask
    // a read ends on drive of sd, a write when the wait line is let go
    task automatic mem_acc(input bit rd, input bit rom, input logic [19:0] ad,
        input logic [15:0] d);
        bit seen;
        seen = 0;
        sa_i = ad;
        sd_i = d;
        rom_window_match_n_i = !rom;
        shared_window_match_n_i = rom;
        memr_n_i = !rd;
        memw_n_i = rd;
        for (int n = 0; n < 300; n++)
        begin
            seen |= iochrdy_oe_o === 1'b1;
            if (rd ? sd_oe_o === 1'b1 : seen && iochrdy_oe_o === 1'b0)
                break;
            if (n == 299)
            begin
                err_total++;
                print_verdict();
            end
            tick(1);
        end
        if (rd)
            cmp(sd_o, d);
        {memr_n_i, memw_n_i, rom_window_match_n_i, shared_window_match_n_i} = 4'hf;
        tick(3);
    endtask
    task automatic wr(input logic [15:0] ad, input logic [15:0] d);
        ref_mem[ad] = d[7:0];
        ref_mem[16'(ad + 1)] = d[15:8];
        mem_acc(0, 0, ad, d);
    endtask
    task automatic rd(input logic [15:0] ad);
        mem_acc(1, 0, ad, {ref_mem[16'(ad + 1)], ref_mem[ad]});
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int c = 0; c < 4; c++)
        begin
            rst_n_i = 0;
            io_base_strap_i = 2'(c);
            tick(6);
            rst_n_i = 1;
            tick(8);
            cmp(shared_mode_o, 1);
            cmp(addr_buffer_output_enable_n_o, 0);
            cmp(dma_request_o, 0);
            foreach (offs[i])
            begin
                sa_i = 20'(20'h300 + c * 32 + offs[i]);
                ior_n_i = 0;
                tick(4);
                cmp(io_select_o, offs[i] < 24);
                if (offs[i] < 24)
                    cmp(io_offset_o, offs[i]);
                ior_n_i = 1;
                tick(4);
            end
        end
        for (int k = 0; k < 6; k++)
        begin
            a = {15'($random(seed)), 1'b0};
            wr(a, 16'($random(seed)));
            wr(16'(a + 2), 16'($random(seed)));
            rd(a);
            rd(16'(a + 2));
            wr(16'(a + 2), 16'($random(seed)));
            rd(16'(a + 2));
            mem_acc(1, 1, a, {a[7:0] ^ 8'ha4, a[7:0] ^ 8'ha5});
        end
        // bus-master pass: rom, i/o and dma decoded on chip
        shared_mode_strap_n_i = 1;
        for (int c = 0; c < 4; c++)
        begin
            rst_n_i = 0;
            io_base_strap_i = 2'(c);
            tick(6);
            rst_n_i = 1;
            tick(8);
            cmp(shared_mode_o, 0);
            cmp(addr_buffer_output_enable_n_o, 1);
            sa_i = 20'(20'h300 + c * 32 + 2);
            iow_n_i = 0;
            tick(4);
            cmp(io_write_o, 1);
            cmp(io_cs16_oe_o, 1);
            iow_n_i = 1;
            mem_acc(1, 1, {6'(6'h32 + c), a[13:0]},
                {a[7:0] ^ 8'ha4, a[7:0] ^ 8'ha5});
            sa_i = {6'(6'h32 + (c ^ 1)), a[13:0]};
            memr_n_i = 0;
            tick(4);
            cmp(rom_chip_select_n_o, 1);
            memr_n_i = 1;
            dack_n_i = 0;
            tick(3);
            repeat (8)
            begin
                req_seen = dma_req_i;
                tick(1);
                cmp(dma_strobe_o, req_seen);
                cmp(dma_request_o, req_seen);
            end
            dack_n_i = 1;
        end
        print_verdict();
    end
endmodule
